// File: verification/host_model.sv
// Host controller model that programs the upconverter control registers.
// Assumes it shares core_clk_in with the register bank and writes whole bytes.
`timescale 1ns/10ps
module host_model
(
  // Clock
  input wire logic core_clk_in,
  // Register write port
  output logic reg_write_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  // Field status
  output logic current_field_parity_out
);
  initial
  begin
    reg_write_out = 1'b0;
    reg_addr_out = 8'hff;
    reg_wdata_out = 8'h00;
    current_field_parity_out = 1'b0;
  end
  // ----------------------------------------
  // Write cycle
  // ----------------------------------------
  // Released lines show the inverse, so a stale byte cannot pass for a live one.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk_in);
    reg_write_out <= 1'b1;
    reg_addr_out <= addr;
    reg_wdata_out <= data;
    @(posedge core_clk_in);
    reg_write_out <= 1'b0;
    reg_addr_out <= ~addr;
    reg_wdata_out <= ~data;
  endtask
  // ----------------------------------------
  // Field programming
  // ----------------------------------------
  // The colour matrix enable lives in another register and is never written here.
  task automatic program_field(input logic interlaced, input logic odd, input logic film_repeat,
    input logic [1:0] aux, output logic [7:0] value);
    logic [1:0] offs;
    offs = !interlaced ? 2'h0 : (odd ? 2'h3 : 2'h1);
    current_field_parity_out <= odd;
    value = {aux, offs, !film_repeat, 2'h3, odd};
    write_reg(8'h28, value);
  endtask
endmodule

// File: verification/tb.sv
// Self-checking bench of the upconverter control register bank.
// Assumes the host model drives the write port while the bench drives fields and data.
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) \
    begin \
      failures++; \
      $display("BAD %s exp %h got %h", nm, ex, got); \
    end \
  end
module tb;
  import upconv_ctrl_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic reg_write, parity, field_start = 1'b0, pred_req = 1'b0;
  logic [7:0] reg_addr, reg_wdata, wr_value;
  logic [7:0] src [11];
  logic [7:0] orig_wr, interp_wr, aux_y, aux_u, aux_v;
  logic pred_en, left_par, nr_par, aux_oe, peak;
  logic [2:0] line_delay;
  logic [5:0] factor;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  host_model host (.core_clk_in(core_clk_in), .reg_write_out(reg_write), .reg_addr_out(reg_addr),
    .reg_wdata_out(reg_wdata), .current_field_parity_out(parity));
  upconverter_control_regs dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_write_in(reg_write),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .field_start_in(field_start),
    .current_field_parity_in(parity), .deint_luma_in(src[0]), .orig_mem_luma_rd_in(src[1]),
    .interp_mem_luma_rd_in(src[2]), .pred_write_req_in(pred_req), .main_y_in(src[3]),
    .main_u_in(src[4]), .main_v_in(src[5]), .second_y_in(src[6]), .second_u_in(src[7]),
    .second_v_in(src[8]), .motion_x_in(src[9]), .motion_y_in(src[10]), .orig_mem_luma_wr_out(orig_wr),
    .interp_mem_luma_wr_out(interp_wr), .pred_mem_write_en_out(pred_en),
    .left_tree_field_parity_out(left_par), .nr_field_parity_out(nr_par),
    .right_tree_line_delay_out(line_delay), .luma_temporal_interp_factor_out(factor),
    .aux_y_out(aux_y), .aux_u_out(aux_u), .aux_v_out(aux_v), .aux_oe_out(aux_oe),
    .vert_peaking_en_out(peak));
  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial
  begin
    forever #20 core_clk_in = ~core_clk_in;
  end
  // The whole run needs about 100 cycles; the ceiling leaves wide margin.
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic set_src(input logic [7:0] b);
    @(posedge core_clk_in);
    foreach (src[i]) src[i] <= b + 8'(i);
  endtask
  task automatic pulse_field();
    @(posedge core_clk_in);
    field_start <= 1'b1;
    @(posedge core_clk_in);
    field_start <= 1'b0;
    settle(1);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    `CHK("left parity", 1'b0, left_par)
    `CHK("line delay", 3'h2, line_delay)
    `CHK("factor", 6'h00, factor)
    `CHK("aux oe", 1'b0, aux_oe)
    `CHK("peaking", 1'b1, peak)
  endtask
  task automatic t_paths();
    set_src(8'h40);
    pred_req <= 1'b1;
    host.write_reg(8'h28, 8'h0f);
    settle(2);
    `CHK("left parity", 1'b1, left_par)
    `CHK("orig wr", src[0], orig_wr)
    `CHK("interp wr", src[0], interp_wr)
    `CHK("pred en", 1'b1, pred_en)
    host.write_reg(8'h28, 8'h08);
    settle(2);
    `CHK("left parity", 1'b0, left_par)
    `CHK("orig wr", src[1], orig_wr)
    `CHK("interp wr", src[2], interp_wr)
    host.write_reg(8'h28, 8'h00);
    settle(2);
    `CHK("pred en", 1'b0, pred_en)
    host.write_reg(8'h2a, 8'hff);
    settle(2);
    `CHK("left parity", 1'b0, left_par)
    `CHK("orig wr", src[1], orig_wr)
  endtask
  task automatic t_offset();
    logic il [3] = '{1'b1, 1'b1, 1'b0};
    logic od [3] = '{1'b1, 1'b0, 1'b0};
    logic [2:0] dl [3] = '{3'h3, 3'h1, 3'h2};
    for (int i = 0; i < 3; i++)
    begin
      host.program_field(il[i], od[i], 1'b0, 2'h0, wr_value);
      pulse_field();
      `CHK("line delay", dl[i], line_delay)
      `CHK("nr parity", od[i], nr_par)
      `CHK("pred en", 1'b1, pred_en)
    end
    host.write_reg(8'h28, 8'h30);
    settle(2);
    `CHK("line delay held", 3'h2, line_delay)
    pulse_field();
    `CHK("line delay", 3'h3, line_delay)
    host.write_reg(8'h28, 8'h20);
    pulse_field();
    `CHK("line delay code 2", 3'h2, line_delay)
  endtask
  task automatic t_aux();
    logic [7:0] ey, eu, ev;
    set_src(8'h80);
    for (int m = 0; m < 4; m++)
    begin
      host.write_reg(8'h28, {2'(m), 6'h00});
      settle(2);
      case (m)
        1:
        begin
          ey = 8'h00;
          eu = src[9];
          ev = src[10];
        end
        2:
        begin
          ey = src[3];
          eu = src[4];
          ev = src[5];
        end
        3:
        begin
          ey = src[6];
          eu = src[7];
          ev = src[8];
        end
        default:
        begin
          ey = 8'h00;
          eu = 8'h00;
          ev = 8'h00;
        end
      endcase
      `CHK("aux oe", (m != 0), aux_oe)
      `CHK("aux y", ey, aux_y)
      `CHK("aux u", eu, aux_u)
      `CHK("aux v", ev, aux_v)
      `CHK("peaking", (m != 3), peak)
    end
  endtask
  task automatic t_factor();
    logic [7:0] fv [6] = '{8'h00, 8'h20, 8'h11, 8'h3f, 8'h21, 8'hc5};
    logic [5:0] fe [6] = '{6'h00, 6'h20, 6'h11, 6'h20, 6'h20, 6'h05};
    for (int i = 0; i < 6; i++)
    begin
      host.write_reg(8'h29, fv[i]);
      settle(2);
      `CHK("factor", fe[i], factor)
    end
    host.write_reg(8'h27, 8'h05);
    settle(2);
    `CHK("factor held", 6'h05, factor)
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    foreach (src[i]) src[i] = 8'h10 + 8'(i);
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    settle(1);
    t_reset();
    t_paths();
    t_offset();
    t_aux();
    t_factor();
    wrap_up();
  end
endmodule

// File: verilog/aux_bus_driver.sv
// Registered driver of the auxiliary output bus.
// Assumes all inputs come from logic on core_clk_in.
`timescale 1ns/10ps
module aux_bus_driver
  import upconv_ctrl_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Mode
  input wire logic [1:0] aux_bus_output_select_in,
  // Sources
  input wire logic [DATA_W-1:0] main_y_in,
  input wire logic [DATA_W-1:0] main_u_in,
  input wire logic [DATA_W-1:0] main_v_in,
  input wire logic [DATA_W-1:0] second_y_in,
  input wire logic [DATA_W-1:0] second_u_in,
  input wire logic [DATA_W-1:0] second_v_in,
  input wire logic [DATA_W-1:0] motion_x_in,
  input wire logic [DATA_W-1:0] motion_y_in,
  // Aux bus
  output logic [DATA_W-1:0] aux_y_out,
  output logic [DATA_W-1:0] aux_u_out,
  output logic [DATA_W-1:0] aux_v_out,
  output logic aux_oe_out,
  output logic vert_peaking_en_out
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (DATA_W < 1)
  begin : g_bad_data_w
    $error("DATA_W must be at least 1.");
  end

  // ----------------------------------------
  // Mode decode and data selection
  // ----------------------------------------
  aux_mode_t mode;
  logic [DATA_W-1:0] next_y;
  logic [DATA_W-1:0] next_u;
  logic [DATA_W-1:0] next_v;
  logic next_oe;
  logic next_peak;

  always_comb
  begin
    case (aux_bus_output_select_in)
      2'h1: mode = AUX_MOTION;
      2'h2: mode = AUX_COPY;
      2'h3: mode = AUX_DOUBLE;
      default: mode = AUX_TRISTATE;
    endcase
  end

  always_comb
  begin
    next_y = '0;
    next_u = '0;
    next_v = '0;
    next_oe = 1'b0;
    next_peak = 1'b1;
    case (mode)
      AUX_TRISTATE:
      begin
        next_oe = 1'b0;
      end
      AUX_MOTION:
      begin
        next_oe = 1'b1;
        next_u = motion_x_in;
        next_v = motion_y_in;
      end
      AUX_COPY:
      begin
        next_oe = 1'b1;
        next_y = main_y_in;
        next_u = main_u_in;
        next_v = main_v_in;
      end
      AUX_DOUBLE:
      begin
        next_oe = 1'b1;
        next_peak = 1'b0;
        next_y = second_y_in;
        next_u = second_u_in;
        next_v = second_v_in;
      end
      default:
      begin
        next_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      aux_y_out <= '0;
      aux_u_out <= '0;
      aux_v_out <= '0;
      aux_oe_out <= 1'b0;
      vert_peaking_en_out <= 1'b1;
    end
    else
    begin
      aux_y_out <= next_y;
      aux_u_out <= next_u;
      aux_v_out <= next_v;
      aux_oe_out <= next_oe;
      vert_peaking_en_out <= next_peak;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_AUX_MOTION_LANES: assert property (@(posedge core_clk_in) disable iff (rst_in)
    aux_bus_output_select_in == 2'h1 |=> aux_oe_out && aux_u_out == $past(motion_x_in)
      && aux_v_out == $past(motion_y_in))
    else $error("Motion vectors not on the chroma lanes.");
  AST_AUX_TRISTATE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    aux_bus_output_select_in == 2'h0 |=> !aux_oe_out && vert_peaking_en_out)
    else $error("Aux bus driven in single output mode.");
  AST_AUX_DOUBLE_PEAK: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !vert_peaking_en_out |-> $past(aux_bus_output_select_in) == 2'h3)
    else $error("Vertical peaking off outside double output.");
endmodule

// File: verilog/upconv_ctrl_pkg.sv
// Constants shared by the upconverter control register bank and its aux bus driver.
// Assumes register writes arrive already decoded from the serial control link.
package upconv_ctrl_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] MEMORY_PATH_CONTROL_ADDR = 8'h28;
  localparam logic [7:0] LUMA_INTERP_FACTOR_ADDR = 8'h29;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] MEMORY_PATH_CONTROL_RESET = 8'h00;
  localparam logic [7:0] LUMA_INTERP_FACTOR_RESET = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int LEFT_PARITY_BIT = 0;
  localparam int ORIG_WRITE_BIT = 1;
  localparam int INTERP_WRITE_BIT = 2;
  localparam int PRED_UPDATE_BIT = 3;
  localparam int NR_OFFSET_LSB = 4;
  localparam int AUX_SELECT_LSB = 6;
  localparam int INTERP_FACTOR_LSB = 0;
  // ----------------------------------------
  // Field codes and limits
  // ----------------------------------------
  localparam logic [1:0] NR_OFFSET_ZERO = 2'h0;
  localparam logic [1:0] NR_OFFSET_PLUS = 2'h1;
  localparam logic [1:0] NR_OFFSET_MINUS = 2'h3;
  localparam logic [5:0] INTERP_FACTOR_MAX = 6'h20;
  localparam logic [2:0] NR_NOMINAL_DELAY = 3'h2;
  typedef enum logic [3:0] {
    AUX_TRISTATE = 4'h1,
    AUX_MOTION = 4'h2,
    AUX_COPY = 4'h4,
    AUX_DOUBLE = 4'h8
  } aux_mode_t;
endpackage

// File: verilog/upconverter_control_regs.sv
// Memory path and luminance upconversion control registers with the logic they steer.
// Assumes the serial link decoder presents one-cycle write strobes on core_clk_in.
`timescale 1ns/10ps
//
// Overview of operation
// - Bit 0 holds left tree field parity.
// - Bit 1 selects de-interlacer or recirculated original luma.
// - Bit 2 selects de-interlacer or recirculated interpolated luma.
// - Bit 3 gates prediction memory writes.
// - Bits 5:4 set right tree offset 0/+1/-1.
// - Larger offset reads less delayed lines.
// - Offset is applied with current field parity.
// - Bits 7:6 select aux bus output mode.
// - Motion mode puts x, y on chroma lanes.
// - Bits 5:0 hold luma interpolation factor 0..32.
module upconverter_control_regs
  import upconv_ctrl_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Register write port
  input wire logic reg_write_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  // Field timing
  input wire logic field_start_in,
  input wire logic current_field_parity_in,
  // Luma paths
  input wire logic [DATA_W-1:0] deint_luma_in,
  input wire logic [DATA_W-1:0] orig_mem_luma_rd_in,
  input wire logic [DATA_W-1:0] interp_mem_luma_rd_in,
  input wire logic pred_write_req_in,
  // Aux bus sources
  input wire logic [DATA_W-1:0] main_y_in,
  input wire logic [DATA_W-1:0] main_u_in,
  input wire logic [DATA_W-1:0] main_v_in,
  input wire logic [DATA_W-1:0] second_y_in,
  input wire logic [DATA_W-1:0] second_u_in,
  input wire logic [DATA_W-1:0] second_v_in,
  input wire logic [DATA_W-1:0] motion_x_in,
  input wire logic [DATA_W-1:0] motion_y_in,
  // Memory path outputs
  output logic [DATA_W-1:0] orig_mem_luma_wr_out,
  output logic [DATA_W-1:0] interp_mem_luma_wr_out,
  output logic pred_mem_write_en_out,
  output logic left_tree_field_parity_out,
  output logic nr_field_parity_out,
  output logic [2:0] right_tree_line_delay_out,
  output logic [5:0] luma_temporal_interp_factor_out,
  // Aux bus
  output logic [DATA_W-1:0] aux_y_out,
  output logic [DATA_W-1:0] aux_u_out,
  output logic [DATA_W-1:0] aux_v_out,
  output logic aux_oe_out,
  output logic vert_peaking_en_out
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // Refused at elaboration, so a bad width never reaches a netlist.
  if (DATA_W < 1)
  begin : g_bad_data_w
    $error("DATA_W must be at least 1.");
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // No read path exists: software must shadow these values itself.
  logic [7:0] memory_path_control;
  logic [7:0] luma_interp_factor;
  logic [7:0] next_memory_path_control;
  logic [7:0] next_luma_interp_factor;

  always_comb
  begin
    next_memory_path_control = memory_path_control;
    next_luma_interp_factor = luma_interp_factor;
    if (reg_write_in && reg_addr_in == MEMORY_PATH_CONTROL_ADDR)
    begin
      next_memory_path_control = reg_wdata_in;
    end
    if (reg_write_in && reg_addr_in == LUMA_INTERP_FACTOR_ADDR)
    begin
      next_luma_interp_factor = reg_wdata_in;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      memory_path_control <= MEMORY_PATH_CONTROL_RESET;
      luma_interp_factor <= LUMA_INTERP_FACTOR_RESET;
    end
    else
    begin
      memory_path_control <= next_memory_path_control;
      luma_interp_factor <= next_luma_interp_factor;
    end
  end

  // ----------------------------------------
  // Field memory and prediction paths
  // ----------------------------------------
  logic [1:0] nr_code;
  logic [1:0] live_nr_code;
  logic [1:0] next_nr_code;
  logic next_nr_parity;
  logic [2:0] next_right_delay;
  logic [5:0] raw_factor;
  logic [5:0] next_factor;
  logic [DATA_W-1:0] next_orig_wr;
  logic [DATA_W-1:0] next_interp_wr;
  logic next_pred_en;

  assign live_nr_code = memory_path_control[NR_OFFSET_LSB +: 2];
  assign raw_factor = luma_interp_factor[INTERP_FACTOR_LSB +: 6];

  always_comb
  begin
    next_orig_wr = memory_path_control[ORIG_WRITE_BIT] ? deint_luma_in : orig_mem_luma_rd_in;
    next_interp_wr = memory_path_control[INTERP_WRITE_BIT] ? deint_luma_in : interp_mem_luma_rd_in;
    next_pred_en = pred_write_req_in && memory_path_control[PRED_UPDATE_BIT];
    // Values above the top of the range would extrapolate past the previous field.
    next_factor = (raw_factor > INTERP_FACTOR_MAX) ? INTERP_FACTOR_MAX : raw_factor;
    // The offset is taken only at a field start, so it never changes inside a field.
    next_nr_code = nr_code;
    next_nr_parity = nr_field_parity_out;
    if (field_start_in)
    begin
      next_nr_code = live_nr_code;
      next_nr_parity = current_field_parity_in;
    end
    case (next_nr_code)
      NR_OFFSET_PLUS: next_right_delay = NR_NOMINAL_DELAY - 3'h1;
      NR_OFFSET_MINUS: next_right_delay = NR_NOMINAL_DELAY + 3'h1;
      default: next_right_delay = NR_NOMINAL_DELAY;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      nr_code <= NR_OFFSET_ZERO;
      nr_field_parity_out <= 1'b0;
      right_tree_line_delay_out <= NR_NOMINAL_DELAY;
      orig_mem_luma_wr_out <= '0;
      interp_mem_luma_wr_out <= '0;
      pred_mem_write_en_out <= 1'b0;
      left_tree_field_parity_out <= 1'b0;
      luma_temporal_interp_factor_out <= 6'h00;
    end
    else
    begin
      nr_code <= next_nr_code;
      nr_field_parity_out <= next_nr_parity;
      right_tree_line_delay_out <= next_right_delay;
      orig_mem_luma_wr_out <= next_orig_wr;
      interp_mem_luma_wr_out <= next_interp_wr;
      pred_mem_write_en_out <= next_pred_en;
      left_tree_field_parity_out <= memory_path_control[LEFT_PARITY_BIT];
      luma_temporal_interp_factor_out <= next_factor;
    end
  end

  // ----------------------------------------
  // Auxiliary bus
  // ----------------------------------------
  aux_bus_driver #(
    .DATA_W(DATA_W)
  ) u_aux (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .aux_bus_output_select_in(memory_path_control[AUX_SELECT_LSB +: 2]),
    .main_y_in(main_y_in),
    .main_u_in(main_u_in),
    .main_v_in(main_v_in),
    .second_y_in(second_y_in),
    .second_u_in(second_u_in),
    .second_v_in(second_v_in),
    .motion_x_in(motion_x_in),
    .motion_y_in(motion_y_in),
    .aux_y_out(aux_y_out),
    .aux_u_out(aux_u_out),
    .aux_v_out(aux_v_out),
    .aux_oe_out(aux_oe_out),
    .vert_peaking_en_out(vert_peaking_en_out)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence write_ctrl_s;
    reg_write_in && reg_addr_in == MEMORY_PATH_CONTROL_ADDR;
  endsequence
  sequence quiet_ctrl_s;
    !(reg_write_in && reg_addr_in == MEMORY_PATH_CONTROL_ADDR) [*2];
  endsequence

  AST_HOLD_VALUE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    write_ctrl_s ##1 quiet_ctrl_s |-> memory_path_control == $past(reg_wdata_in, 2))
    else $error("Control value not held after write.");
  AST_LEFT_PARITY: assert property (@(posedge core_clk_in) disable iff (rst_in)
    write_ctrl_s ##1 quiet_ctrl_s |-> left_tree_field_parity_out == $past(reg_wdata_in[0], 2))
    else $error("Left tree parity does not follow bit 0.");
  AST_ORIG_PATH: assert property (@(posedge core_clk_in) disable iff (rst_in)
    memory_path_control[ORIG_WRITE_BIT] |=> orig_mem_luma_wr_out == $past(deint_luma_in))
    else $error("Original memory not fed from de-interlacer.");
  AST_ORIG_RECIRC: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !memory_path_control[ORIG_WRITE_BIT] |=> orig_mem_luma_wr_out == $past(orig_mem_luma_rd_in))
    else $error("Original memory not recirculated.");
  AST_INTERP_PATH: assert property (@(posedge core_clk_in) disable iff (rst_in)
    1'b1 |=> interp_mem_luma_wr_out == ($past(memory_path_control[INTERP_WRITE_BIT])
      ? $past(deint_luma_in) : $past(interp_mem_luma_rd_in)))
    else $error("Interpolated memory path wrong.");
  AST_PRED_GATE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    pred_mem_write_en_out |-> $past(pred_write_req_in) && $past(memory_path_control[PRED_UPDATE_BIT]))
    else $error("Prediction write while keep selected.");
  AST_NR_MINUS: assert property (@(posedge core_clk_in) disable iff (rst_in)
    field_start_in && live_nr_code == NR_OFFSET_MINUS |=> right_tree_line_delay_out == 3'h3)
    else $error("Offset -1 does not read more delayed lines.");
  AST_NR_PLUS: assert property (@(posedge core_clk_in) disable iff (rst_in)
    field_start_in && live_nr_code == NR_OFFSET_PLUS |=> right_tree_line_delay_out == 3'h1
      && nr_field_parity_out == $past(current_field_parity_in))
    else $error("Offset +1 or field parity not applied.");
  AST_FACTOR_RANGE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    1'b1 |=> luma_temporal_interp_factor_out <= 6'h20
      && ($past(raw_factor) > 6'h20 || luma_temporal_interp_factor_out == $past(raw_factor)))
    else $error("Interpolation factor out of range.");
endmodule
